// ---- design/jcls_map.svh ----
// Purpose: Constants for the TAP configuration load sequencer
// Assumes: Included by design files by bare name
// Notes: Counts are in test clock cycles unless named _CYC
`ifndef JCLS_MAP_SVH
`define JCLS_MAP_SVH
`define JCLS_RESET_TCKS 4'h5
`define JCLS_SEL_TCKS 4'h2
`define JCLS_IR_LEN 4'h5
`define JCLS_IR_CFG_IN 5'h05
`define JCLS_IR_START 5'h0c
`define JCLS_IR_BYPASS 5'h1f
`define JCLS_STARTUP_TCKS 8'h0e
`define JCLS_PAD_BASE 6'h20
`define JCLS_TCK_PERIOD_NS 16'h007d
`define JCLS_CLK_PERIOD_NS 16'h0005
`define JCLS_HALF_CYC 8'h0c
`endif

// ---- design/jcls_pkg.sv ----
// Purpose: Types for the TAP configuration load sequencer
// Assumes: Constants live in jcls_map.svh
// Notes: None
package jcls_pkg;
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jcls_tap_t;
    typedef enum logic [3:0] {
        ST_IDLE, ST_RESET, ST_RTI, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_SEL_DR, ST_CAP_DR, ST_PAD, ST_DATA, ST_STARTUP, ST_UPD_DR,
        ST_DONE
    } jcls_state_t;
endpackage

// ---- design/jcls_sequencer.sv ----
// Purpose: Drives a device chain through its TAP to load a bitstream
// Assumes: Bitstream words arrive MSB first on a valid/ready stream
// Notes: One target per load; startup launch goes to every device
//
// Function
// - Hold mode select high five test clocks after power-up to reset TAP.
// - Mode select low one clock to reach run-test/idle.
// - Mode select high two clocks to reach instruction-select.
// - Mode select low two clocks to enter instruction shift.
// - Configuration-input code low four bits shifted with mode select low.
// - Last instruction bit zero shifted with mode select high.
// - Mode select high two clocks after instruction load to data-select.
// - Mode select low two clocks to enter data shift.
// - Bitstream shifted MSB first, count minus one clocks, mode select low.
// - Final bitstream bit shifted with mode select high into exit1.
// - After update, high two clocks then low two to instruction shift; here one low clock to idle, launch is a later job.
// - Startup-launch code low bits shifted right-most first.
// - Last startup-launch bit zero with mode select high one clock.
// - Clock data shift at least twelve times; fourteen used here.
// - Update with mode select high then one low clock to idle.
// - Right-most printed instruction bit is shifted first.
// - Bitstream must choose test-clock startup; the user supplies it.
// - Load only one device per pass, never several at once.
// - Target gets configuration-input, all others get bypass.
// - Shift 32 minus position modulo 32 leading zeros before bitstream.
// - Chain positions count from zero at the first device.
// - Final launch goes to all devices then twelve-plus data clocks.
`timescale 1ns/1ps
`include "jcls_map.svh"
module jcls_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Job control
    input wire logic start,
    input wire logic launch,
    input wire logic [5:0] target_pos,
    input wire logic [5:0] chain_len,
    input wire logic [31:0] bit_count,
    output logic busy,
    output logic done,
    // Bitstream stream, 32-bit words MSB first
    input wire logic [31:0] bs_data,
    input wire logic bs_valid,
    output logic bs_ready,
    // TAP pins
    output jcls_pkg::jcls_tap_t tap,
    input wire logic tdo
);
    jcls_pkg::jcls_state_t st_ff, nxt_st;
    logic run;
    logic fall;
    logic tck_w;
    logic tms_ff, nxt_tms;
    logic tdi_ff, nxt_tdi;
    logic [31:0] cnt_ff, nxt_cnt;
    logic [31:0] left_ff, nxt_left;
    logic [31:0] word_ff, nxt_word;
    logic [5:0] wbit_ff, nxt_wbit;
    logic [5:0] pos_ff, nxt_pos;
    logic [5:0] tgt_ff, nxt_tgt;
    logic [5:0] len_ff, nxt_len;
    logic cfg_ff, nxt_cfg;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic rdy_ff, nxt_rdy;
    logic tdo_s1_ff, tdo_s2_ff;
    logic [5:0] ir_bits;
    logic [4:0] ir_code;
    logic [5:0] head_pos;
    logic [4:0] head_code;
    logic [5:0] pad;

    jcls_tck_gen u_tck (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .run(run),
        .tck(tck_w),
        .fall(fall)
    );

    assign run = busy_ff;

    // Device-side tdo is unused for loading; synchronised for later use
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            tdo_s1_ff <= 1'b0;
            tdo_s2_ff <= 1'b0;
        end
        else if (ce)
        begin
            tdo_s1_ff <= tdo;
            tdo_s2_ff <= tdo_s1_ff;
        end
    end

    // Devices after position zero: last device is shifted first
    assign ir_code = (cfg_ff && (pos_ff != tgt_ff)) ? `JCLS_IR_BYPASS
        : (cfg_ff ? `JCLS_IR_CFG_IN : `JCLS_IR_START);
    assign ir_bits = {2'b00, `JCLS_IR_LEN};
    // First bit of the next device's code; pos_ff still names the old one
    assign head_pos = (st_ff == jcls_pkg::ST_SHIFT_IR) ? pos_ff - 6'h01
        : len_ff - 6'h01;
    assign head_code = (cfg_ff && (head_pos != tgt_ff)) ? `JCLS_IR_BYPASS
        : (cfg_ff ? `JCLS_IR_CFG_IN : `JCLS_IR_START);
    // Modulo 32 is the low five bits of the position
    assign pad = `JCLS_PAD_BASE - {1'b0, tgt_ff[4:0]};

    always_comb
    begin
        nxt_st = st_ff;
        nxt_tms = tms_ff;
        nxt_tdi = tdi_ff;
        nxt_cnt = cnt_ff;
        nxt_left = left_ff;
        nxt_word = word_ff;
        nxt_wbit = wbit_ff;
        nxt_pos = pos_ff;
        nxt_tgt = tgt_ff;
        nxt_len = len_ff;
        nxt_cfg = cfg_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_rdy = 1'b0;
        case (st_ff)
        jcls_pkg::ST_IDLE:
        begin
            // One job at a time; starts ignored while busy
            if (start || launch)
            begin
                nxt_busy = 1'b1;
                nxt_cfg = start;
                nxt_tgt = target_pos;
                nxt_len = (chain_len == 6'h00) ? 6'h01 : chain_len;
                nxt_left = bit_count;
                nxt_st = jcls_pkg::ST_RESET;
                nxt_tms = 1'b1;
                nxt_cnt = 32'h0;
            end
        end
        default:
        begin
            if (fall)
            begin
                nxt_cnt = cnt_ff + 32'h1;
                case (st_ff)
                jcls_pkg::ST_RESET:
                begin
                    if (cnt_ff[3:0] == `JCLS_RESET_TCKS - 4'h1)
                    begin
                        nxt_tms = 1'b0;
                        nxt_cnt = 32'h0;
                        nxt_st = jcls_pkg::ST_RTI;
                    end
                end
                jcls_pkg::ST_RTI:
                begin
                    nxt_tms = 1'b1;
                    nxt_cnt = 32'h0;
                    nxt_st = jcls_pkg::ST_SEL_IR;
                end
                jcls_pkg::ST_SEL_IR:
                begin
                    if (cnt_ff[3:0] == `JCLS_SEL_TCKS - 4'h1)
                    begin
                        nxt_tms = 1'b0;
                        nxt_cnt = 32'h0;
                        nxt_st = jcls_pkg::ST_CAP_IR;
                    end
                end
                jcls_pkg::ST_CAP_IR:
                begin
                    if (cnt_ff[3:0] == `JCLS_SEL_TCKS - 4'h1)
                    begin
                        // Last device in the chain is shifted first
                        nxt_pos = len_ff - 6'h01;
                        nxt_wbit = 6'h00;
                        nxt_tdi = head_code[0];
                        nxt_cnt = 32'h0;
                        nxt_st = jcls_pkg::ST_SHIFT_IR;
                    end
                end
                jcls_pkg::ST_SHIFT_IR:
                begin
                    nxt_wbit = wbit_ff + 6'h01;
                    if (wbit_ff == ir_bits - 6'h01)
                    begin
                        if (pos_ff == 6'h00)
                        begin
                            nxt_tms = 1'b1;
                            nxt_cnt = 32'h0;
                            nxt_st = jcls_pkg::ST_SEL_DR;
                        end
                        else
                        begin
                            nxt_pos = pos_ff - 6'h01;
                            nxt_wbit = 6'h00;
                            nxt_tdi = head_code[0];
                        end
                    end
                    else
                    begin
                        // Bit after the current one, right-most first
                        nxt_tdi = ir_code[wbit_ff[2:0] + 3'h1];
                        // Final bit of the whole chain leaves shift
                        if (pos_ff == 6'h00 && wbit_ff == ir_bits - 6'h02)
                        begin
                            nxt_tms = 1'b1;
                        end
                    end
                end
                jcls_pkg::ST_SEL_DR:
                begin
                    // Exit1 rise already taken: update-ir, then select-dr
                    if (cnt_ff[3:0] == `JCLS_SEL_TCKS - 4'h1)
                    begin
                        nxt_tms = 1'b0;
                        nxt_cnt = 32'h0;
                        nxt_st = jcls_pkg::ST_CAP_DR;
                    end
                end
                jcls_pkg::ST_CAP_DR:
                begin
                    if (cnt_ff[3:0] == `JCLS_SEL_TCKS - 4'h1)
                    begin
                        nxt_cnt = 32'h0;
                        nxt_tdi = 1'b0;
                        nxt_st = cfg_ff ? jcls_pkg::ST_PAD
                            : jcls_pkg::ST_STARTUP;
                    end
                end
                jcls_pkg::ST_PAD:
                begin
                    // Needs the first word on hand before leaving padding
                    if (cnt_ff[5:0] >= pad - 6'h01 && bs_valid)
                    begin
                        nxt_word = bs_data;
                        nxt_rdy = 1'b1;
                        nxt_tdi = bs_data[31];
                        nxt_wbit = 6'h01;
                        nxt_tms = (left_ff == 32'h1);
                        nxt_left = left_ff - 32'h1;
                        nxt_st = jcls_pkg::ST_DATA;
                    end
                end
                jcls_pkg::ST_DATA:
                begin
                    if (left_ff == 32'h0)
                    begin
                        // The last bit's rise was already the exit1 clock
                        nxt_tms = 1'b1;
                        nxt_st = jcls_pkg::ST_UPD_DR;
                        nxt_cnt = 32'h1;
                    end
                    else if (wbit_ff[5])
                    begin
                        // Late data repeats the last bit: keep words ahead
                        if (bs_valid)
                        begin
                            nxt_word = bs_data;
                            nxt_rdy = 1'b1;
                            nxt_tdi = bs_data[31];
                            nxt_wbit = 6'h01;
                            nxt_tms = (left_ff == 32'h1);
                            nxt_left = left_ff - 32'h1;
                        end
                    end
                    else
                    begin
                        nxt_tdi = word_ff[5'h1f - wbit_ff[4:0]];
                        nxt_wbit = wbit_ff + 6'h01;
                        nxt_tms = (left_ff == 32'h1);
                        nxt_left = left_ff - 32'h1;
                    end
                end
                jcls_pkg::ST_STARTUP:
                begin
                    if (cnt_ff[7:0] == `JCLS_STARTUP_TCKS - 8'h01)
                    begin
                        nxt_tms = 1'b1;
                        nxt_cnt = 32'h0;
                        nxt_st = jcls_pkg::ST_UPD_DR;
                    end
                end
                jcls_pkg::ST_UPD_DR:
                begin
                    // Exit1 then update with mode select high
                    if (cnt_ff[3:0] == 4'h1)
                    begin
                        // Launch only ever comes from a later job
                        nxt_cnt = 32'h0;
                        nxt_tms = 1'b0;
                        nxt_st = jcls_pkg::ST_DONE;
                    end
                end
                jcls_pkg::ST_DONE:
                begin
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                    nxt_st = jcls_pkg::ST_IDLE;
                end
                default:
                begin
                    nxt_st = jcls_pkg::ST_IDLE;
                end
                endcase
            end
        end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_ff <= jcls_pkg::ST_IDLE;
            tms_ff <= 1'b1;
            tdi_ff <= 1'b0;
            cnt_ff <= 32'h0;
            left_ff <= 32'h0;
            word_ff <= 32'h0;
            wbit_ff <= 6'h00;
            pos_ff <= 6'h00;
            tgt_ff <= 6'h00;
            len_ff <= 6'h01;
            cfg_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end
        else if (ce)
        begin
            st_ff <= nxt_st;
            tms_ff <= nxt_tms;
            tdi_ff <= nxt_tdi;
            cnt_ff <= nxt_cnt;
            left_ff <= nxt_left;
            word_ff <= nxt_word;
            wbit_ff <= nxt_wbit;
            pos_ff <= nxt_pos;
            tgt_ff <= nxt_tgt;
            len_ff <= nxt_len;
            cfg_ff <= nxt_cfg;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            rdy_ff <= nxt_rdy;
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;
    assign bs_ready = rdy_ff;
    assign tap = '{tck: tck_w, tms: tms_ff, tdi: tdi_ff};
endmodule

// ---- design/jcls_tck_gen.sv ----
// Purpose: Divides clk into the test clock and flags its falling edges
// Assumes: clk at 200 MHz; half period in clk cycles from the map
// Notes: Pins change on the falling edge, device samples on rising
`timescale 1ns/1ps
`include "jcls_map.svh"
module jcls_tck_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Control
    input wire logic run,
    // Strobes and clock
    output logic tck,
    output logic fall
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic tck_ff;
    logic nxt_tck;
    logic fall_ff;
    logic nxt_fall;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_tck = tck_ff;
        nxt_fall = 1'b0;
        if (!run)
        begin
            nxt_cnt = 8'h00;
            nxt_tck = 1'b0;
        end
        else if (cnt_ff == `JCLS_HALF_CYC - 8'h01)
        begin
            nxt_cnt = 8'h00;
            nxt_tck = ~tck_ff;
            nxt_fall = tck_ff;
        end
        else
        begin
            nxt_cnt = cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_ff <= 8'h00;
            tck_ff <= 1'b0;
            fall_ff <= 1'b0;
        end
        else if (ce)
        begin
            cnt_ff <= nxt_cnt;
            tck_ff <= nxt_tck;
            fall_ff <= nxt_fall;
        end
    end

    assign tck = tck_ff;
    assign fall = fall_ff;
endmodule

// ---- tb/jcls_chain_model.sv ----
// Purpose: Behavioural chain of boundary-scan devices
// Assumes: Shared tck and tms; device 0 sits next to tdi
// Notes: Logs every bit shifted in data shift since the last capture-dr
`timescale 1ns/1ps
module jcls_chain_model #(
    parameter int NDEV = 3
) (
    // TAP pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo
);
    // Next state for mode select low and high
    localparam int NX0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11,
        13, 13, 11, 1};
    localparam int NX1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12,
        15, 14, 15, 2};
    // Power-up state is arbitrary, so the host must reset the TAP
    int st = 4;
    bit saw_tlr = 1'b0;
    logic [5*NDEV-1:0] ir_sr = '0;
    logic [5*NDEV-1:0] ir_ff = '0;
    logic [NDEV-1:0] byp_ff = '0;
    logic flip_ff = 1'b0;
    logic dr_log[$];
    // Undriven outside shift states: show a moving pattern
    assign tdo = (st == 4 || st == 11) ? byp_ff[NDEV-1] : flip_ff;
    always @(posedge tck)
    begin
        flip_ff <= ~flip_ff;
        if (st == 0)
            saw_tlr <= 1'b1;
        if (st == 3)
            dr_log.delete();
        if (st == 4)
        begin
            byp_ff <= {byp_ff[NDEV-2:0], tdi};
            dr_log.push_back(tdi);
        end
        if (st == 11)
            ir_sr <= {tdi, ir_sr[5*NDEV-1:1]};
        if (st == 15)
            ir_ff <= ir_sr;
        st <= tms ? NX1[st] : NX0[st];
    end
endmodule

// ---- tb/jcls_sequencer_props.sv ----
// Purpose: Port checks for the TAP load sequencer
// Assumes: Test clock high phase is twelve clk cycles
// Notes: Bound below to every sequencer instance
`timescale 1ns/1ps
module jcls_sequencer_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Job control
    input wire logic start,
    input wire logic launch,
    input wire logic busy,
    input wire logic done,
    input wire logic bs_ready,
    // TAP pins
    input wire jcls_pkg::jcls_tap_t tap
);
    logic [7:0] hi_cnt_ff;
    logic [7:0] nxt_hi_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Counter, since a twelve-long repetition is too costly to unroll
    always_comb
    begin
        nxt_hi_cnt = tap.tck ? hi_cnt_ff + 8'h01 : 8'h00;
        if (reset)
            nxt_hi_cnt = 8'h00;
    end
    always_ff @(posedge clk)
    begin
        hi_cnt_ff <= nxt_hi_cnt;
    end
    chk_reset_rest: assert property (
        @(posedge clk) disable iff (1'b0)
        reset |=> tap.tms && !tap.tck && !busy && !done && !bs_ready)
        else $error("pins not at rest after reset");
    chk_job_taken: assert property (
        start && !busy && ce |=> busy)
        else $error("start not taken");
    chk_done_single: assert property (
        done |=> !done)
        else $error("done longer than one cycle");
    chk_done_idle: assert property (
        done && !start && !launch |=> !busy)
        else $error("busy after done");
    chk_busy_end: assert property (
        $fell(busy) |-> done || $past(done))
        else $error("busy fell without done");
    chk_word_pulse: assert property (
        bs_ready |=> !bs_ready)
        else $error("word ready longer than one cycle");
    chk_word_in_job: assert property (
        bs_ready |-> busy)
        else $error("word taken outside a job");
    chk_pins_settled: assert property (
        !$stable({tap.tms, tap.tdi}) |-> !tap.tck)
        else $error("pins moved while test clock high");
    chk_tck_half: assert property (
        $fell(tap.tck) |-> hi_cnt_ff == 8'h0c)
        else $error("test clock high phase wrong");
    chk_tck_in_job: assert property (
        $rose(tap.tck) |-> busy)
        else $error("test clock outside a job");
endmodule
bind jcls_sequencer jcls_sequencer_props chk (.clk(clk), .reset(reset),
    .ce(ce), .start(start), .launch(launch), .busy(busy), .done(done),
    .bs_ready(bs_ready), .tap(tap));

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the TAP load sequencer
// Assumes: Three-device chain model on the TAP pins
// Notes: Expected bits come from the word table, MSB first
`timescale 1ns/1ps
module tb;
    localparam int NDEV = 3;
    logic clk;
    logic reset;
    logic ce;
    logic start;
    logic launch;
    logic [5:0] target_pos;
    logic [5:0] chain_len;
    logic [31:0] bit_count;
    logic busy;
    logic done;
    logic [31:0] bs_data;
    logic bs_valid;
    logic bs_ready;
    jcls_pkg::jcls_tap_t tap;
    logic tdo;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] words [2] = '{32'hc3a5_9e01, 32'h8d7f_0000};

    jcls_sequencer dut (.clk(clk), .reset(reset), .ce(ce), .start(start),
        .launch(launch), .target_pos(target_pos), .chain_len(chain_len),
        .bit_count(bit_count), .busy(busy), .done(done), .bs_data(bs_data),
        .bs_valid(bs_valid), .bs_ready(bs_ready), .tap(tap), .tdo(tdo));
    jcls_chain_model #(.NDEV(NDEV)) peer (.tck(tap.tck), .tms(tap.tms),
        .tdi(tap.tdi), .tdo(tdo));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One job; words stall gap cycles apart; poke tries a refused start
    task automatic run_job(input logic cfg, input logic both,
        input logic [5:0] pos, input logic [31:0] nbits, input int gap,
        input logic poke);
        int t;
        int u;
        int w;
        @(posedge clk);
        #1;
        target_pos = pos;
        chain_len = 6'(NDEV);
        bit_count = nbits;
        peer.saw_tlr = 1'b0;
        start = cfg;
        launch = both | ~cfg;
        t = 0;
        while (busy !== 1'b1 && t < 4)
        begin
            @(posedge clk);
            #1;
            t++;
        end
        check(busy, 1'b1);
        start = 1'b0;
        launch = 1'b0;
        fork
            for (w = 0; cfg && 32 * w < nbits; w++)
            begin
                repeat (gap) @(posedge clk);
                #1;
                bs_data = words[w];
                bs_valid = 1'b1;
                t = 0;
                do
                begin
                    @(posedge clk);
                    #1;
                    t++;
                end while (bs_ready !== 1'b1 && t < 20000);
                bs_valid = 1'b0;
                bs_data = ~bs_data;
            end
            begin
                repeat (400) @(posedge clk);
                #1;
                start = poke;
                target_pos = 6'h01;
                @(posedge clk);
                #1;
                start = 1'b0;
                u = 0;
                while (done !== 1'b1 && u < 20000)
                begin
                    @(posedge clk);
                    #1;
                    u++;
                end
                check(done, 1'b1);
            end
        join
    endtask

    task automatic check_result(input logic cfg, input logic [5:0] pos,
        input logic [31:0] nbits);
        int pad;
        int i;
        logic [4:0] e;
        pad = cfg ? 32 - (pos % 32) : 0;
        check(peer.saw_tlr, 1'b1);
        check(peer.st, 1);
        for (i = 0; i < NDEV; i++)
        begin
            e = (NDEV - 1 - i == pos) ? 5'h05 : 5'h1f;
            check(peer.ir_ff[5*i+:5], cfg ? e : 5'h0c);
        end
        // Launch: fourteen startup clocks plus the exit clock, which shifts too
        check(peer.dr_log.size(), cfg ? pad + nbits : 15);
        for (i = 0; i < pad; i++)
            check(peer.dr_log[i], 1'b0);
        for (i = 0; i < nbits; i++)
            check(peer.dr_log[pad+i], words[i/32][31-i%32]);
    endtask

    task automatic test_cfg_first();
        run_job(1'b1, 1'b0, 6'h00, 32'h28, 3, 1'b1);
        check_result(1'b1, 6'h00, 32'h28);
        $display("test cfg_first finished");
    endtask

    task automatic test_cfg_last();
        run_job(1'b1, 1'b1, 6'h02, 32'h01, 1, 1'b0);
        check_result(1'b1, 6'h02, 32'h01);
        $display("test cfg_last finished");
    endtask

    task automatic test_launch();
        run_job(1'b0, 1'b0, 6'h00, 32'h00, 1, 1'b1);
        check_result(1'b0, 6'h00, 32'h00);
        $display("test launch finished");
    endtask

    // Reset in mid-job, then a launch from wherever the TAP was left
    task automatic test_reset_abort();
        @(posedge clk);
        #1;
        start = 1'b1;
        repeat (300) @(posedge clk);
        #1;
        start = 1'b0;
        reset = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check({tap.tck, tap.tms, busy, done, bs_ready}, 5'h08);
        reset = 1'b0;
        test_launch();
        $display("test reset_abort finished");
    endtask

    initial
    begin
        reset = 1'b1;
        ce = 1'b1;
        start = 1'b0;
        launch = 1'b0;
        target_pos = 6'h00;
        chain_len = 6'h03;
        bit_count = 32'h0;
        bs_data = 32'h0;
        bs_valid = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        reset = 1'b0;
        test_cfg_first();
        test_cfg_last();
        test_launch();
        test_reset_abort();
        finish_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
